// File: inc/adc_ctrl_pkg.sv
// Register map constants for the channel control and status register bank.
package adc_ctrl_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int CHANNELS = 8;
	localparam int PAIRS    = 4;
	localparam int OUTPUTS  = 4;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [6:0] OFS_OVERFLOW_STATUS = 7'h02;
	localparam logic [6:0] OFS_OVERFLOW_MASK   = 7'h03;
	localparam logic [6:0] OFS_HIGHPASS        = 7'h04;
	localparam logic [6:0] OFS_POWER_DOWN      = 7'h06;
	localparam logic [6:0] OFS_CHANNEL_MUTE    = 7'h08;
	localparam logic [6:0] OFS_SERIAL_DISABLE  = 7'h0a;
	localparam logic [6:0] OFS_RESERVED_A      = 7'h05;
	localparam logic [6:0] OFS_RESERVED_B      = 7'h07;
	localparam logic [6:0] OFS_RESERVED_C      = 7'h09;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_OVERFLOW_STATUS = 8'hff;
	localparam logic [7:0] RST_OVERFLOW_MASK   = 8'hff;
	localparam logic [7:0] RST_HIGHPASS        = 8'h00;
	localparam logic [7:0] RST_POWER_DOWN      = 8'h00;
	localparam logic [7:0] RST_CHANNEL_MUTE    = 8'h00;
	localparam logic [7:0] RST_SERIAL_DISABLE  = 8'h00;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int POS_POINTER_POINTER_AUTO_INCREMENT   = 7;
	localparam int POS_REFERENCE_OFF  = 5;
	localparam int POS_OSCILLATOR_OFF = 4;
	localparam logic [7:0] MASK_POWER_DOWN     = 8'h3f;
	localparam logic [7:0] MASK_SERIAL_DISABLE = 8'h0f;

endpackage

// File: inc/overflow_if.sv
// Carrier between the register bank and its overflow flag unit.
interface overflow_if;
	logic [7:0] events;
	logic       read_clear;
	logic [7:0] pin_mask;
	logic [7:0] status_n;
	logic       pin_low;

	modport unit (
		input  events,
		input  read_clear,
		input  pin_mask,
		output status_n,
		output pin_low
	);

	modport bank (
		output events,
		output read_clear,
		output pin_mask,
		input  status_n,
		input  pin_low
	);
endinterface

// File: src/overflow_flag_unit.sv
// Sticky overflow flags that clear on read, and the masked pin request.
module overflow_flag_unit (
	input  wire logic   i_ref_clk,
	input  wire logic   i_sys_rst,
	overflow_if.unit    ovf
);

	typedef struct packed {
		logic [7:0] flags;
	} flag_state_t;

	flag_state_t state_reg;
	flag_state_t state_next;

	// ------------------------------------------------------------------
	// Flag update
	// ------------------------------------------------------------------
	// A read clears what was captured; an event in the same cycle stays.
	always_comb begin
		state_next = state_reg;
		if (ovf.read_clear) begin
			state_next.flags = ovf.events;
		end else begin
			state_next.flags = state_reg.flags | ovf.events;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg.flags <= ~adc_ctrl_pkg::RST_OVERFLOW_STATUS;
		end else begin
			state_reg <= state_next;
		end
	end

	assign ovf.status_n = ~state_reg.flags;
	assign ovf.pin_low  = |(state_reg.flags & ovf.pin_mask);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_event_kept;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		ovf.events != 8'h00 |=> (ovf.status_n & $past(ovf.events)) == 8'h00;
	endproperty
	a_event_kept: assert property (p_event_kept)
		else $error("overflow event lost");

	property p_sticky;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!ovf.read_clear |=> (ovf.status_n & ~$past(ovf.status_n)) == 8'h00;
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("overflow flag released without read");

endmodule // overflow_flag_unit

// File: src/adc_channel_control_regs.sv
// Per-channel control and status register bank of the converter.
//
// Notes on behaviour
// - Overflow status reads 0xff after reset: no overflow recorded.
// - Overflow drives its status bit low and pulls the overflow pin low.
// - Status bits stay asserted until the host reads the status register.
// - Overflow mask resets to 0xff, every channel may act on the pin.
// - Masked channel still records overflow; with the control port enabled it never moves the pin.
// - One filter bit per channel; reset zero keeps all filters active.
// - Power-down register resets to zero: everything powered and clocked.
// - Bit five switches off the internal voltage reference.
// - Bit four stops the internal oscillator core.
// - Bit four also blocks an external master clock from the logic.
// - Bits three to zero stop a channel pair and zero its data.
// - Mute register resets to zero: no channel muted.
// - A muted channel sends all-zero sample words.
// - Output-disable register resets to zero: all four outputs driven.
// - Low four disable bits tri-state their output; upper four unused.
// - Register values act only once the control-port enable is set.
// - Pointer advances after each byte only when auto-increment is set.
module adc_channel_control_regs (
	input  wire logic       i_ref_clk,
	input  wire logic       i_sys_rst,
	input  wire logic       i_control_port_enable,
	input  wire logic       i_pointer_write,
	input  wire logic [7:0] i_pointer_byte,
	input  wire logic       i_data_write,
	input  wire logic [7:0] i_write_byte,
	input  wire logic       i_data_read,
	input  wire logic [7:0] i_overflow_event,
	output logic      [7:0] o_read_byte,
	output logic            o_overflow_pin_out,
	output logic            o_overflow_pin_oe_n,
	output logic      [7:0] o_dc_filter_disable,
	output logic            o_reference_power_off,
	output logic            o_oscillator_power_off,
	output logic            o_core_clock_enable,
	output logic      [3:0] o_pair_clock_enable,
	output logic      [7:0] o_channel_force_zero,
	output logic      [3:0] o_serial_out_oe_n,
	output logic      [6:0] o_pointer,
	output logic            o_pointer_auto_increment
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [6:0] pointer;
		logic       auto_pointer_auto_increment;
		logic [7:0] pin_mask;
		logic [7:0] filter;
		logic [7:0] power;
		logic [7:0] mute;
		logic [7:0] out_dis;
		logic [7:0] read_byte;
		logic [7:0] filter_eff;
		logic [7:0] power_eff;
		logic [7:0] zero_eff;
		logic [3:0] oe_n_eff;
	} bank_state_t;

	bank_state_t state_reg;
	bank_state_t state_next;

	overflow_if ovf ();

	// ------------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------------
	function automatic logic [7:0] read_value(
		input logic [6:0] addr,
		input bank_state_t st,
		input logic [7:0] status_n
	);
		logic [7:0] value;
		value = 8'h00;
		unique case (addr)
			adc_ctrl_pkg::OFS_OVERFLOW_STATUS: value = status_n;
			adc_ctrl_pkg::OFS_OVERFLOW_MASK:   value = st.pin_mask;
			adc_ctrl_pkg::OFS_HIGHPASS:        value = st.filter;
			adc_ctrl_pkg::OFS_POWER_DOWN:      value = st.power;
			adc_ctrl_pkg::OFS_CHANNEL_MUTE:    value = st.mute;
			adc_ctrl_pkg::OFS_SERIAL_DISABLE:  value = st.out_dis;
			default:                           value = 8'h00;
		endcase
		return value;
	endfunction

	// Pair power-down expanded to the two channels of each pair.
	function automatic logic [7:0] pair_to_channels(input logic [3:0] p);
		return {p[3], p[3], p[2], p[2], p[1], p[1], p[0], p[0]};
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		if (i_pointer_write) begin
			state_next.pointer   = i_pointer_byte[6:0];
			state_next.auto_pointer_auto_increment =
				i_pointer_byte[adc_ctrl_pkg::POS_POINTER_POINTER_AUTO_INCREMENT];
		end else if (i_data_write || i_data_read) begin
			if (state_reg.auto_pointer_auto_increment) begin
				state_next.pointer = state_reg.pointer + 7'h01;
			end
		end
		if (i_data_read && !i_pointer_write) begin
			state_next.read_byte =
				read_value(state_reg.pointer, state_reg, ovf.status_n);
		end
		if (i_data_write && !i_pointer_write) begin
			unique case (state_reg.pointer)
				adc_ctrl_pkg::OFS_OVERFLOW_MASK: begin
					state_next.pin_mask = i_write_byte;
				end
				adc_ctrl_pkg::OFS_HIGHPASS: begin
					state_next.filter = i_write_byte;
				end
				adc_ctrl_pkg::OFS_POWER_DOWN: begin
					state_next.power =
						i_write_byte & adc_ctrl_pkg::MASK_POWER_DOWN;
				end
				adc_ctrl_pkg::OFS_CHANNEL_MUTE: begin
					state_next.mute = i_write_byte;
				end
				adc_ctrl_pkg::OFS_SERIAL_DISABLE: begin
					state_next.out_dis =
						i_write_byte & adc_ctrl_pkg::MASK_SERIAL_DISABLE;
				end
				default: begin
				end
			endcase
		end
		if (i_control_port_enable) begin
			state_next.filter_eff = state_next.filter;
			state_next.power_eff  = state_next.power;
			state_next.zero_eff   = state_next.mute
				| pair_to_channels(state_next.power[3:0]);
			state_next.oe_n_eff   = state_next.out_dis[3:0];
		end else begin
			state_next.filter_eff = adc_ctrl_pkg::RST_HIGHPASS;
			state_next.power_eff  = adc_ctrl_pkg::RST_POWER_DOWN;
			state_next.zero_eff   = adc_ctrl_pkg::RST_CHANNEL_MUTE;
			state_next.oe_n_eff   = adc_ctrl_pkg::RST_SERIAL_DISABLE[3:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_reg.pointer    <= 7'h00;
			state_reg.auto_pointer_auto_increment  <= 1'b0;
			state_reg.pin_mask   <= adc_ctrl_pkg::RST_OVERFLOW_MASK;
			state_reg.filter     <= adc_ctrl_pkg::RST_HIGHPASS;
			state_reg.power      <= adc_ctrl_pkg::RST_POWER_DOWN;
			state_reg.mute       <= adc_ctrl_pkg::RST_CHANNEL_MUTE;
			state_reg.out_dis    <= adc_ctrl_pkg::RST_SERIAL_DISABLE;
			state_reg.read_byte  <= 8'h00;
			state_reg.filter_eff <= adc_ctrl_pkg::RST_HIGHPASS;
			state_reg.power_eff  <= adc_ctrl_pkg::RST_POWER_DOWN;
			state_reg.zero_eff   <= adc_ctrl_pkg::RST_CHANNEL_MUTE;
			state_reg.oe_n_eff   <= adc_ctrl_pkg::RST_SERIAL_DISABLE[3:0];
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Overflow flags
	// ------------------------------------------------------------------
	// The mask acts only under the control port; otherwise all channels act.
	assign ovf.events     = i_overflow_event;
	assign ovf.read_clear = i_data_read && !i_pointer_write
		&& state_reg.pointer == adc_ctrl_pkg::OFS_OVERFLOW_STATUS;
	assign ovf.pin_mask   = i_control_port_enable ? state_reg.pin_mask
		: adc_ctrl_pkg::RST_OVERFLOW_MASK;

	overflow_flag_unit u_flags (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.ovf       (ovf.unit)
	);

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// The open-drain pin only ever pulls low; released it floats high.
	assign o_overflow_pin_out     = 1'b0;
	assign o_overflow_pin_oe_n    = ~ovf.pin_low;
	assign o_read_byte            = state_reg.read_byte;
	assign o_dc_filter_disable    = state_reg.filter_eff;
	assign o_reference_power_off  =
		state_reg.power_eff[adc_ctrl_pkg::POS_REFERENCE_OFF];
	assign o_oscillator_power_off =
		state_reg.power_eff[adc_ctrl_pkg::POS_OSCILLATOR_OFF];
	assign o_core_clock_enable    =
		~state_reg.power_eff[adc_ctrl_pkg::POS_OSCILLATOR_OFF];
	assign o_pair_clock_enable    = ~state_reg.power_eff[3:0];
	assign o_channel_force_zero   = state_reg.zero_eff;
	assign o_serial_out_oe_n      = state_reg.oe_n_eff;
	assign o_pointer              = state_reg.pointer;
	assign o_pointer_auto_increment = state_reg.auto_pointer_auto_increment;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	logic access;
	assign access = (i_data_write || i_data_read) && !i_pointer_write;

	sequence s_status_read;
		i_data_read && !i_pointer_write
		&& o_pointer == adc_ctrl_pkg::OFS_OVERFLOW_STATUS;
	endsequence

	sequence s_quiet_after;
		i_overflow_event == 8'h00 && !i_pointer_write;
	endsequence

	property p_reset_values;
		@(posedge i_ref_clk)
		i_sys_rst |=> ovf.status_n == 8'hff && state_reg.pin_mask == 8'hff
			&& o_channel_force_zero == 8'h00 && o_serial_out_oe_n == 4'h0
			&& o_pair_clock_enable == 4'hf && o_core_clock_enable;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register bank reset value wrong");

	property p_mask_reset;
		@(posedge i_ref_clk)
		i_sys_rst |=> state_reg.pin_mask == 8'hff && state_reg.filter == 8'h00
			&& state_reg.power == 8'h00 && state_reg.mute == 8'h00;
	endproperty
	a_mask_reset: assert property (p_mask_reset)
		else $error("control register reset value wrong");

	property p_pin_follows;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!o_overflow_pin_oe_n == |(~ovf.status_n & ovf.pin_mask);
	endproperty
	a_pin_follows: assert property (p_pin_follows)
		else $error("overflow pin disagrees with unmasked flags");

	property p_overflow_to_pin;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(i_overflow_event & ovf.pin_mask) != 8'h00 |=> !o_overflow_pin_oe_n;
	endproperty
	a_overflow_to_pin: assert property (p_overflow_to_pin)
		else $error("unmasked overflow did not pull pin low");

	property p_read_clears;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_status_read ##1 s_quiet_after |=> ovf.status_n
			== ($past(ovf.read_clear) ? 8'hff : ~$past(i_overflow_event, 2));
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read did not clear flags");

	property p_read_returns;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		s_status_read |=> o_read_byte == $past(ovf.status_n);
	endproperty
	a_read_returns: assert property (p_read_returns)
		else $error("status read returned wrong value");

	property p_pointer_step;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		access |=> o_pointer == ($past(o_pointer_auto_increment)
			? $past(o_pointer) + 7'h01 : $past(o_pointer));
	endproperty
	a_pointer_step: assert property (p_pointer_step)
		else $error("pointer step wrong after data byte");

	property p_mute_zero;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_control_port_enable && !i_data_write ##1 i_control_port_enable
			|-> o_channel_force_zero == (state_reg.mute
			| pair_to_channels(state_reg.power[3:0]));
	endproperty
	a_mute_zero: assert property (p_mute_zero)
		else $error("muted or powered-down channel not forced to zero");

	property p_standalone;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!i_control_port_enable |=> o_serial_out_oe_n == 4'h0
			&& o_channel_force_zero == 8'h00 && o_core_clock_enable
			&& o_dc_filter_disable == 8'h00;
	endproperty
	a_standalone: assert property (p_standalone)
		else $error("registers acted without control port enable");

	property p_oe_follows;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_control_port_enable |=> o_serial_out_oe_n
			== $past(state_next.out_dis[3:0]);
	endproperty
	a_oe_follows: assert property (p_oe_follows)
		else $error("serial output enable does not follow register");

	property p_osc_blocks;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		o_oscillator_power_off |-> !o_core_clock_enable;
	endproperty
	a_osc_blocks: assert property (p_osc_blocks)
		else $error("core clock enabled while oscillator off");

	property p_reserved_zero;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_data_read && !i_pointer_write
		&& (o_pointer == adc_ctrl_pkg::OFS_RESERVED_A
		|| o_pointer == adc_ctrl_pkg::OFS_RESERVED_B
		|| o_pointer == adc_ctrl_pkg::OFS_RESERVED_C)
		|=> o_read_byte == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved address read nonzero");

	property p_pointer_load;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		i_pointer_write |=> o_pointer == $past(i_pointer_byte[6:0])
			&& o_pointer_auto_increment
			== $past(i_pointer_byte[adc_ctrl_pkg::POS_POINTER_POINTER_AUTO_INCREMENT]);
	endproperty
	a_pointer_load: assert property (p_pointer_load)
		else $error("pointer byte not loaded");

	property p_pointer_hold;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		!i_pointer_write && !access |=> $stable(o_pointer);
	endproperty
	a_pointer_hold: assert property (p_pointer_hold)
		else $error("pointer moved without an access");

	property p_unused_bits;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(state_reg.power & ~adc_ctrl_pkg::MASK_POWER_DOWN) == 8'h00
			&& (state_reg.out_dis & ~adc_ctrl_pkg::MASK_SERIAL_DISABLE)
			== 8'h00;
	endproperty
	a_unused_bits: assert property (p_unused_bits)
		else $error("unused control bit was stored");

	property p_pair_zero;
		@(posedge i_ref_clk) disable iff (i_sys_rst)
		(pair_to_channels(~o_pair_clock_enable) & ~o_channel_force_zero)
			== 8'h00;
	endproperty
	a_pair_zero: assert property (p_pair_zero)
		else $error("powered-down pair still sends data");

endmodule // adc_channel_control_regs

// File: dv/host_port_model.sv
// Host controller model that drives the register port of the bank.
module host_port_model (
	input  wire logic       i_ref_clk,
	input  wire logic [7:0] i_read_byte,
	output logic            o_pointer_write,
	output logic      [7:0] o_pointer_byte,
	output logic            o_data_write,
	output logic      [7:0] o_write_byte,
	output logic            o_data_read
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_pointer_write = 1'b0;
		o_pointer_byte  = 8'h00;
		o_data_write    = 1'b0;
		o_write_byte    = 8'h00;
		o_data_read     = 1'b0;
	end

	// Each task starts just after a falling edge, holds its strobe for one
	// cycle and then lets one idle cycle pass, so that two calls in a row
	// never raise a strobe in the time step that lowered it.
	// Released data lines show the inverse of their last value.
	task automatic set_ptr(input logic inc, input logic [6:0] addr);
		o_pointer_byte  = {inc, addr};
		o_pointer_write = 1'b1;
		@(negedge i_ref_clk);
		o_pointer_write = 1'b0;
		o_pointer_byte  = ~o_pointer_byte;
		@(negedge i_ref_clk);
	endtask

	task automatic wr(input logic [7:0] d);
		o_write_byte = d;
		o_data_write = 1'b1;
		@(negedge i_ref_clk);
		o_data_write = 1'b0;
		o_write_byte = ~o_write_byte;
		@(negedge i_ref_clk);
	endtask

	task automatic rd(output logic [7:0] d);
		o_data_read = 1'b1;
		@(negedge i_ref_clk);
		o_data_read = 1'b0;
		d = i_read_byte;
		@(negedge i_ref_clk);
	endtask
endmodule // host_port_model

// File: dv/adc_channel_control_regs_tb.sv
// Self-checking bench for the channel control and status register bank.
module adc_channel_control_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       i_ref_clk             = 1'b0;
	logic       i_sys_rst             = 1'b1;
	logic       i_control_port_enable = 1'b0;
	logic [7:0] i_overflow_event      = 8'h00;
	logic       ptr_wr, dat_wr, dat_rd, ovf_out, ovf_oe_n;
	logic       ref_off, osc_off, core_en, ptr_inc;
	logic [7:0] ptr_byte, wr_byte, rd_byte, hpf_dis, force_zero;
	logic [3:0] pair_en, sd_oe_n;
	logic [6:0] ptr;
	// The overflow pin is open drain with a pull-up.
	wire        pin_level = ovf_oe_n ? 1'b1 : ovf_out;
	int         failures  = 0;
	int         tests_run = 0;
	int         reg_mdl[16];
	int         ptr_mdl, inc_mdl, seed_val;

	always #20 i_ref_clk = ~i_ref_clk;

	host_port_model host_port_model_i (.i_ref_clk(i_ref_clk),
		.i_read_byte(rd_byte), .o_pointer_write(ptr_wr),
		.o_pointer_byte(ptr_byte), .o_data_write(dat_wr),
		.o_write_byte(wr_byte), .o_data_read(dat_rd));

	adc_channel_control_regs adc_channel_control_regs_i (
		.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
		.i_control_port_enable(i_control_port_enable),
		.i_pointer_write(ptr_wr), .i_pointer_byte(ptr_byte),
		.i_data_write(dat_wr), .i_write_byte(wr_byte),
		.i_data_read(dat_rd), .i_overflow_event(i_overflow_event),
		.o_read_byte(rd_byte), .o_overflow_pin_out(ovf_out),
		.o_overflow_pin_oe_n(ovf_oe_n), .o_dc_filter_disable(hpf_dis),
		.o_reference_power_off(ref_off), .o_oscillator_power_off(osc_off),
		.o_core_clock_enable(core_en), .o_pair_clock_enable(pair_en),
		.o_channel_force_zero(force_zero), .o_serial_out_oe_n(sd_oe_n),
		.o_pointer(ptr), .o_pointer_auto_increment(ptr_inc));

	// ------------------------------------------------------------------
	// Model and comparison tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
			input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_all();
		logic       en;
		logic       pend;
		logic [7:0] msk;
		logic [7:0] pz;
		en = i_control_port_enable;
		pz = 8'h00;
		for (int k = 0; k < 4; k++) pz[2*k +: 2] = {2{reg_mdl[6][k]}};
		msk  = en ? reg_mdl[3][7:0] : 8'hff;
		pend = |(reg_mdl[2][7:0] & msk);
		chk({6'h00, ovf_out, ovf_oe_n}, {7'h00, ~pend}, "pin drive");
		chk({7'h00, pin_level}, {7'h00, ~pend}, "pin level");
		chk(hpf_dis, en ? reg_mdl[4][7:0] : 8'h00, "filter");
		chk({6'h00, ref_off, osc_off},
			en ? {6'h00, reg_mdl[6][5:4]} : 8'h00, "power");
		chk({3'h0, core_en, pair_en},
			en ? {3'h0, ~reg_mdl[6][4], ~reg_mdl[6][3:0]} : 8'h1f, "clocks");
		chk(force_zero, en ? (reg_mdl[8][7:0] | pz) : 8'h00, "zero");
		chk({4'h0, sd_oe_n}, en ? {4'h0, reg_mdl[10][3:0]} : 8'h00, "serial_audio_output_pin");
		chk({ptr_inc, ptr}, {inc_mdl[0], ptr_mdl[6:0]}, "pointer");
	endtask

	task automatic step_ptr();
		if (inc_mdl != 0) ptr_mdl = (ptr_mdl + 1) % 128;
	endtask

	task automatic pulse(input logic [7:0] ev);
		i_overflow_event = ev;
		@(negedge i_ref_clk);
		i_overflow_event = 8'h00;
	endtask

	task automatic do_event(input logic [7:0] ev);
		pulse(ev);
		reg_mdl[2] |= ev;
	endtask

	task automatic do_ptr(input int inc, input int a);
		host_port_model_i.set_ptr(inc[0], a[6:0]);
		inc_mdl = inc;
		ptr_mdl = a;
	endtask

	task automatic do_wr(input logic [7:0] d);
		host_port_model_i.wr(d);
		case (ptr_mdl)
			3, 4, 8: reg_mdl[ptr_mdl] = d;
			6: reg_mdl[6] = d & 8'h3f;
			10: reg_mdl[10] = d & 8'h0f;
			default: ;
		endcase
		step_ptr();
	endtask

	// Reads the register at the pointer while an overflow event arrives.
	task automatic do_rd(input logic [7:0] ev);
		logic [7:0] got;
		logic [7:0] exp;
		exp = 8'h00;
		if (ptr_mdl inside {3, 4, 6, 8, 10}) exp = reg_mdl[ptr_mdl][7:0];
		if (ptr_mdl == 2) exp = ~reg_mdl[2][7:0];
		fork
			host_port_model_i.rd(got);
			pulse(ev);
		join
		if (ptr_mdl == 2) reg_mdl[2] = 0;
		reg_mdl[2] |= ev;
		chk(got, exp, "read");
		step_ptr();
	endtask

	task automatic do_reset();
		i_sys_rst = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		i_sys_rst = 1'b0;
		reg_mdl = '{default: 0};
		reg_mdl[3] = 255;
		ptr_mdl = 0;
		inc_mdl = 0;
	endtask

	task automatic end_test(input string name);
		$display("test %s done, %0d mismatches so far", name, failures);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		failures++;
		$display("[ERR] %0t run did not finish in time", $time);
		give_verdict();
	end

	initial begin
		seed_val = $urandom(32'h024e2758);
		do_reset();
		check_all();
		do_ptr(1, 0);
		repeat (12) do_rd(8'h00);
		end_test("defaults");

		do_ptr(1, 0);
		for (int a = 0; a < 12; a++) do_wr(8'($urandom));
		check_all();
		i_control_port_enable = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		check_all();
		do_ptr(1, 2);
		repeat (9) do_rd(8'h00);
		do_ptr(0, 8);
		repeat (2) do_wr(8'($urandom));
		repeat (2) do_rd(8'h00);
		do_ptr(1, 127);
		do_rd(8'h00);
		check_all();
		end_test("write and pointer");

		for (int b = 0; b < 8; b++) begin
			do_ptr(1, 4);
			repeat (7) do_wr(8'h01 << b);
			check_all();
		end
		end_test("single bits");

		do_ptr(1, 3);
		do_wr(8'h5a);
		do_ptr(0, 2);
		for (int k = 0; k < 8; k++) begin
			do_event(8'h01 << k);
			@(negedge i_ref_clk);
			check_all();
			do_rd(8'h00);
			check_all();
		end
		do_event(8'h81);
		do_rd(8'h24);
		check_all();
		do_rd(8'h00);
		do_event(8'h01);
		i_control_port_enable = 1'b0;
		repeat (2) @(negedge i_ref_clk);
		check_all();
		i_control_port_enable = 1'b1;
		repeat (2) @(negedge i_ref_clk);
		for (int n = 0; n < 24; n++) begin
			do_event(8'($urandom));
			if (n % 3 == 0) do_rd(8'($urandom));
			check_all();
		end
		end_test("overflow");

		do_event(8'hff);
		do_reset();
		check_all();
		do_ptr(0, 2);
		do_rd(8'h00);
		end_test("second reset");
		give_verdict();
	end
endmodule // adc_channel_control_regs_tb
